/* File: logic/uirq_defs.svh */
// Register offsets, field positions, reset values and masks of the interrupt status block.
`ifndef UIRQ_DEFS_SVH
`define UIRQ_DEFS_SVH

`define UIRQ_ADDR_W 8
`define UIRQ_STATUS_OFS 8'h00
`define UIRQ_ENABLE_OFS 8'h04
`define UIRQ_POWER_OFS 8'h08

`define UIRQ_BIT_RD_ERR 29
`define UIRQ_BIT_TIMEOUT 19
`define UIRQ_BIT_DONE 18
`define UIRQ_BIT_ADDR_REQ 17
`define UIRQ_BIT_RST_END 10
`define UIRQ_BIT_RST 9
`define UIRQ_BIT_SUSP 8
`define UIRQ_MIRROR_LSB 0
`define UIRQ_MIRROR_MSB 7

`define UIRQ_PWR_BIT_RST 0
`define UIRQ_PWR_BIT_SUSP 1

`define UIRQ_STICKY_MASK 32'h200E_0700
`define UIRQ_STATUS_RST 32'h0000_0000
`define UIRQ_ENABLE_RST 32'h0000_0000
`define UIRQ_RDATA_RST 32'h0000_0000

`define UIRQ_SYNC_STAGES 3

`endif

/* File: logic/uirq_pkg.sv */
// Types shared by the interrupt status block.
`include "uirq_defs.svh"

package uirq_pkg;

   // Flag outputs of the device controller core, in status bit order for the mirrors.
   typedef struct packed {
      logic bus_reset;
      logic suspend;
      logic nak;
      logic endpoint;
      logic ctrl_endpoint;
      logic sof;
      logic rx_zero;
      logic status_stage;
      logic status_nak;
      logic setup;
   } uirq_core_flags_t;

   typedef enum logic [1:0] {
      UIRQ_SEL_STATUS = 2'h0,
      UIRQ_SEL_ENABLE = 2'h1,
      UIRQ_SEL_POWER = 2'h3,
      UIRQ_SEL_NONE = 2'h2
   } uirq_sel_t;

   typedef struct packed {
      logic [31:0] flags;
      logic [31:0] enable;
      logic [31:0] rdata;
      logic rdy;
      logic err;
      logic bus_reset_prev;
      logic suspend_prev;
   } uirq_state_t;

   localparam uirq_state_t UIRQ_STATE_RST = '{
      flags: `UIRQ_STATUS_RST,
      enable: `UIRQ_ENABLE_RST,
      rdata: `UIRQ_RDATA_RST,
      rdy: 1'b0,
      err: 1'b0,
      bus_reset_prev: 1'b0,
      suspend_prev: 1'b0
   };

endpackage : uirq_pkg

/* File: logic/uirq_sync.sv */
// Three-stage input synchroniser that passes a bit once its last two stages agree.
`timescale 1ns/1ps

module uirq_sync #(
   parameter int WIDTH = 10
) (
   // Clock, reset and clock enable.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // Asynchronous input and settled output.
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   typedef struct packed {
      logic [WIDTH-1:0] st1;
      logic [WIDTH-1:0] st2;
      logic [WIDTH-1:0] st3;
      logic [WIDTH-1:0] settled;
   } uirq_sync_state_t;

   uirq_sync_state_t s_q;
   uirq_sync_state_t s_d;

   if (WIDTH < 1) begin : g_bad_width
      $error("uirq_sync needs WIDTH of at least one.");
   end

   // The first stage is read only by the second, so a metastable value never fans out.
   always_comb begin
      s_d = s_q;
      s_d.st1 = din;
      s_d.st2 = s_q.st1;
      s_d.st3 = s_q.st2;
      for (int i = 0; i < WIDTH; i++) begin
         if (s_q.st2[i] == s_q.st3[i]) begin
            s_d.settled[i] = s_q.st3[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign dout = s_q.settled;

endmodule : uirq_sync

/* File: logic/uirq_top.sv */
// Interrupt status, enable and power view of the device controller bridge, with an APB slave.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "uirq_defs.svh"

module uirq_top
   import uirq_pkg::*;
(
   // Clock, reset and clock enable.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`UIRQ_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Master write engine events, on this clock.
   input wire logic mw_timeout_evt,
   input wire logic mw_done_evt,
   input wire logic mw_rx_data_evt,
   input wire logic mw_enable,
   input wire logic mw_start_evt,
   input wire logic ep_common_bus,
   // Core flag outputs, asynchronous to this clock.
   input uirq_core_flags_t core_flags,
   // Interrupt request.
   output logic irq
);

   uirq_state_t s_q;
   uirq_state_t s_d;
   uirq_core_flags_t core_s;
   logic [7:0] mirrors;
   logic [31:0] status_word;
   logic [31:0] power_word;
   logic [31:0] set_v;
   logic [31:0] clr_v;
   logic wr_fire;
   logic xfer_done;
   uirq_sel_t rd_sel;
   uirq_sel_t wr_sel;

   // Maps a byte address onto one of the three registers, or onto none when no offset matches.
   function automatic uirq_sel_t reg_sel(input logic [`UIRQ_ADDR_W-1:0] addr);
      uirq_sel_t sel;
      unique case (addr)
         `UIRQ_STATUS_OFS: sel = UIRQ_SEL_STATUS;
         `UIRQ_ENABLE_OFS: sel = UIRQ_SEL_ENABLE;
         `UIRQ_POWER_OFS: sel = UIRQ_SEL_POWER;
         default: sel = UIRQ_SEL_NONE;
      endcase
      return sel;
   endfunction : reg_sel

   // Core flags come from another clock, so every bit is settled before use.
   uirq_sync #(
      .WIDTH($bits(uirq_core_flags_t))
   ) u_core_sync (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .din(core_flags),
      .dout(core_s)
   );

   // Mirrors carry no latch here; they clear when the core's own register is cleared.
   assign mirrors = {core_s.nak, core_s.endpoint, core_s.ctrl_endpoint, core_s.sof,
                     core_s.rx_zero, core_s.status_stage, core_s.status_nak,
                     core_s.setup};

   always_comb begin
      status_word = s_q.flags;
      status_word[`UIRQ_MIRROR_MSB:`UIRQ_MIRROR_LSB] = mirrors;
      power_word = '0;
      power_word[`UIRQ_PWR_BIT_RST] = core_s.bus_reset;
      power_word[`UIRQ_PWR_BIT_SUSP] = core_s.suspend;
   end

   // The answer is prepared in the setup cycle, so every access has no wait state
   // unless the clock enable holds the block.
   assign pready = psel && penable && s_q.rdy && clk_en;
   assign xfer_done = pready;
   assign wr_fire = xfer_done && pwrite;
   assign pslverr = pready && s_q.err;
   assign prdata = s_q.rdata;
   assign rd_sel = reg_sel(paddr);
   assign wr_sel = reg_sel(paddr);

   always_comb begin
      s_d = s_q;
      set_v = '0;
      clr_v = '0;
      set_v[`UIRQ_BIT_TIMEOUT] = mw_timeout_evt;
      set_v[`UIRQ_BIT_DONE] = mw_done_evt;
      set_v[`UIRQ_BIT_ADDR_REQ] = mw_rx_data_evt && !mw_enable;
      set_v[`UIRQ_BIT_RD_ERR] = mw_start_evt && ep_common_bus;
      set_v[`UIRQ_BIT_RST_END] = s_q.bus_reset_prev && !core_s.bus_reset;
      set_v[`UIRQ_BIT_RST] = !s_q.bus_reset_prev && core_s.bus_reset;
      set_v[`UIRQ_BIT_SUSP] = s_q.suspend_prev != core_s.suspend;
      s_d.bus_reset_prev = core_s.bus_reset;
      s_d.suspend_prev = core_s.suspend;
      if (wr_fire && wr_sel == UIRQ_SEL_STATUS) begin
         clr_v = pwdata & `UIRQ_STICKY_MASK;
      end
      // A new event wins over a clear in the same cycle, so none is lost.
      s_d.flags = ((s_q.flags & ~clr_v) | set_v) & `UIRQ_STICKY_MASK;
      if (wr_fire && wr_sel == UIRQ_SEL_ENABLE) begin
         s_d.enable = pwdata & `UIRQ_STICKY_MASK;
      end
      if (psel && !s_q.rdy) begin
         s_d.rdy = 1'b1;
         s_d.err = rd_sel == UIRQ_SEL_NONE;
         unique case (rd_sel)
            UIRQ_SEL_STATUS: s_d.rdata = status_word;
            UIRQ_SEL_ENABLE: s_d.rdata = s_q.enable;
            UIRQ_SEL_POWER: s_d.rdata = power_word;
            UIRQ_SEL_NONE: s_d.rdata = '0;
         endcase
      end else if (xfer_done) begin
         s_d.rdy = 1'b0;
         s_d.err = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= UIRQ_STATE_RST;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // Mirrors are not gated here: they have no enable and reach the core's own interrupt.
   assign irq = |(s_q.flags & s_q.enable);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_timeout_sets: assert property (
      clk_en && mw_timeout_evt |=> s_q.flags[`UIRQ_BIT_TIMEOUT])
      else $error("Timeout event did not set its flag.");

   chk_done_sets: assert property (
      clk_en && mw_done_evt |=> s_q.flags[`UIRQ_BIT_DONE])
      else $error("Completion event did not set its flag.");

   chk_addr_request: assert property (
      clk_en && mw_rx_data_evt && !mw_enable && !s_q.flags[`UIRQ_BIT_ADDR_REQ]
      |=> s_q.flags[`UIRQ_BIT_ADDR_REQ])
      else $error("Address request flag missed.");

   chk_addr_quiet: assert property (
      clk_en && !s_q.flags[`UIRQ_BIT_ADDR_REQ] && !(mw_rx_data_evt && !mw_enable)
      |=> !s_q.flags[`UIRQ_BIT_ADDR_REQ])
      else $error("Address request flag set without cause.");

   chk_reset_release: assert property (
      clk_en && s_q.bus_reset_prev && !core_s.bus_reset |=> s_q.flags[`UIRQ_BIT_RST_END])
      else $error("Bus reset release not flagged.");

   chk_reset_assert: assert property (
      clk_en && !s_q.bus_reset_prev && core_s.bus_reset |=> s_q.flags[`UIRQ_BIT_RST])
      else $error("Bus reset assertion not flagged.");

   chk_suspend_change: assert property (
      clk_en && $changed(core_s.suspend) |=> s_q.flags[`UIRQ_BIT_SUSP])
      else $error("Suspend change not flagged.");

   chk_read_error: assert property (
      clk_en && mw_start_evt && ep_common_bus |=> s_q.flags[`UIRQ_BIT_RD_ERR])
      else $error("Endpoint read error not flagged.");

   chk_mirror_read: assert property (
      clk_en && psel && !s_q.rdy && rd_sel == UIRQ_SEL_STATUS
      |=> s_q.rdata[`UIRQ_MIRROR_MSB:`UIRQ_MIRROR_LSB] == $past(mirrors))
      else $error("Status read does not show core interrupt mirrors.");

   chk_w1c_clear: assert property (
      wr_fire && wr_sel == UIRQ_SEL_STATUS && pwdata[`UIRQ_BIT_DONE] && !mw_done_evt
      |=> !s_q.flags[`UIRQ_BIT_DONE])
      else $error("Writing one did not clear the flag.");

   chk_flag_holds: assert property (
      clk_en && s_q.flags[`UIRQ_BIT_TIMEOUT]
      && !(wr_fire && wr_sel == UIRQ_SEL_STATUS && pwdata[`UIRQ_BIT_TIMEOUT])
      |=> s_q.flags[`UIRQ_BIT_TIMEOUT])
      else $error("Flag dropped without a clear.");

   chk_enable_gate: assert property (
      wr_fire && wr_sel == UIRQ_SEL_ENABLE && s_q.enable == '0 && pwdata == '0
      |=> !irq)
      else $error("Interrupt high with every enable off.");

   chk_irq_raise: assert property (
      clk_en && mw_timeout_evt && s_q.enable[`UIRQ_BIT_TIMEOUT]
      && !(wr_fire && wr_sel == UIRQ_SEL_ENABLE) |=> irq)
      else $error("Enabled event did not raise the interrupt.");

   chk_zero_wait: assert property (
      clk_en && psel && !penable && !s_q.rdy ##1 clk_en && psel && penable |-> pready)
      else $error("Access phase was not answered at once.");

   // A clear flag stays clear unless its own event arrives in that cycle.
   chk_timeout_quiet: assert property (
      clk_en && !s_q.flags[`UIRQ_BIT_TIMEOUT] && !mw_timeout_evt
      |=> !s_q.flags[`UIRQ_BIT_TIMEOUT])
      else $error("Timeout flag set without cause.");

   chk_done_quiet: assert property (
      clk_en && !s_q.flags[`UIRQ_BIT_DONE] && !mw_done_evt
      |=> !s_q.flags[`UIRQ_BIT_DONE])
      else $error("Completion flag set without cause.");

   chk_rd_err_quiet: assert property (
      clk_en && !s_q.flags[`UIRQ_BIT_RD_ERR] && !(mw_start_evt && ep_common_bus)
      |=> !s_q.flags[`UIRQ_BIT_RD_ERR])
      else $error("Endpoint read error flag set without cause.");

   chk_release_quiet: assert property (
      clk_en && !s_q.flags[`UIRQ_BIT_RST_END] && !(s_q.bus_reset_prev && !core_s.bus_reset)
      |=> !s_q.flags[`UIRQ_BIT_RST_END])
      else $error("Bus reset release flag set without cause.");

   chk_assert_quiet: assert property (
      clk_en && !s_q.flags[`UIRQ_BIT_RST] && !(!s_q.bus_reset_prev && core_s.bus_reset)
      |=> !s_q.flags[`UIRQ_BIT_RST])
      else $error("Bus reset assertion flag set without cause.");

   chk_suspend_quiet: assert property (
      clk_en && !s_q.flags[`UIRQ_BIT_SUSP] && s_q.suspend_prev == core_s.suspend
      |=> !s_q.flags[`UIRQ_BIT_SUSP])
      else $error("Suspend flag set without a change.");

   chk_release_holds: assert property (
      clk_en && s_q.flags[`UIRQ_BIT_RST_END]
      && !(wr_fire && wr_sel == UIRQ_SEL_STATUS && pwdata[`UIRQ_BIT_RST_END])
      |=> s_q.flags[`UIRQ_BIT_RST_END])
      else $error("Bus reset release flag dropped without a clear.");

   chk_suspend_holds: assert property (
      clk_en && s_q.flags[`UIRQ_BIT_SUSP]
      && !(wr_fire && wr_sel == UIRQ_SEL_STATUS && pwdata[`UIRQ_BIT_SUSP])
      |=> s_q.flags[`UIRQ_BIT_SUSP])
      else $error("Suspend flag dropped without a clear.");

   chk_rd_err_holds: assert property (
      clk_en && s_q.flags[`UIRQ_BIT_RD_ERR]
      && !(wr_fire && wr_sel == UIRQ_SEL_STATUS && pwdata[`UIRQ_BIT_RD_ERR])
      |=> s_q.flags[`UIRQ_BIT_RD_ERR])
      else $error("Endpoint read error flag dropped without a clear.");

   chk_addr_holds: assert property (
      clk_en && s_q.flags[`UIRQ_BIT_ADDR_REQ]
      && !(wr_fire && wr_sel == UIRQ_SEL_STATUS && pwdata[`UIRQ_BIT_ADDR_REQ])
      |=> s_q.flags[`UIRQ_BIT_ADDR_REQ])
      else $error("Address request flag dropped without a clear.");

   chk_enable_write: assert property (
      wr_fire && wr_sel == UIRQ_SEL_ENABLE
      |=> s_q.enable == ($past(pwdata) & `UIRQ_STICKY_MASK))
      else $error("Enable register did not take the written value.");

   chk_enable_holds: assert property (
      clk_en && !(wr_fire && wr_sel == UIRQ_SEL_ENABLE) |=> $stable(s_q.enable))
      else $error("Enable register changed without a write.");

   chk_power_read: assert property (
      clk_en && psel && !s_q.rdy && rd_sel == UIRQ_SEL_POWER
      |=> s_q.rdata == {30'h0, $past(core_s.suspend), $past(core_s.bus_reset)})
      else $error("Power read does not show the live core levels.");

   chk_irq_clears: assert property (
      wr_fire && wr_sel == UIRQ_SEL_STATUS && pwdata == 32'hFFFF_FFFF && set_v == '0
      |=> !irq)
      else $error("Interrupt stayed high after every flag was cleared.");

   cov_irq_raised: cover property (!irq ##1 irq);
   cov_clear_race: cover property (
      wr_fire && wr_sel == UIRQ_SEL_STATUS && pwdata[`UIRQ_BIT_DONE] && mw_done_evt);
   cov_bus_reset_cycle: cover property (
      s_q.flags[`UIRQ_BIT_RST] && s_q.flags[`UIRQ_BIT_RST_END]);
   cov_unmapped: cover property (pslverr);
   cov_frozen_access: cover property (psel && penable && !clk_en);

endmodule : uirq_top

/* File: verification/tb_top.sv */
// Self-checking bench for the interrupt status block.
`timescale 1ns/1ps
`include "uirq_defs.svh"

module tb_top
   import uirq_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] d;
   logic pready;
   logic pslverr;
   logic irq;
   logic clk_en = 1'b1;
   logic [5:0] ev = 6'h00;
   logic [9:0] req = 10'h000;
   uirq_core_flags_t core_flags;
   logic [32:0] q[$];
   int n_mismatch = 0;
   int checks = 0;

   always #10 pclk = ~pclk;

   uirq_core_model CORE (.req(req), .core_flags(core_flags));

   uirq_top DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .mw_timeout_evt(ev[5]),
      .mw_done_evt(ev[4]), .mw_rx_data_evt(ev[3]), .mw_enable(ev[2]),
      .mw_start_evt(ev[1]), .ep_common_bus(ev[0]), .core_flags(core_flags), .irq(irq));

   task automatic chk(input logic [32:0] g, input logic [32:0] e);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : wrap_up

   // Expected read answers are queued at setup and retired when the access completes.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
                      input logic [32:0] e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      if (!w) q.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      apb(1'b0, a, 32'h0, e);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, v, 33'h0);
   endtask : wr

   task automatic ev_p(input logic [5:0] v);
      @(posedge pclk);
      ev <= v;
      @(posedge pclk);
      ev <= 6'h00;
   endtask : ev_p

   // The synchroniser needs about four edges, so eight leaves margin.
   task automatic setc(input logic [9:0] v);
      @(posedge pclk);
      req <= v;
      repeat (8) @(posedge pclk);
   endtask : setc

   task automatic chk_irq(input logic v);
      @(negedge pclk);
      chk({32'h0, irq}, {32'h0, v});
   endtask : chk_irq

   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata}, q.pop_front());
   end

   initial begin
      #400000;
      n_mismatch++;
      $display("[ERR] %0t watchdog expired", $time);
      wrap_up();
   end

   initial begin
      void'($urandom(32'h12B48651));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(`UIRQ_STATUS_OFS, 33'h0);
      rd(`UIRQ_ENABLE_OFS, 33'h0);
      rd(8'h0C, 33'h1_0000_0000);
      wr(8'h0C, 32'hFFFF_FFFF);
      wr(`UIRQ_POWER_OFS, 32'hFFFF_FFFF);
      rd(`UIRQ_POWER_OFS, 33'h0);
      $display("test reset_map done");
      d = $urandom;
      wr(`UIRQ_ENABLE_OFS, d);
      rd(`UIRQ_ENABLE_OFS, {1'b0, d & `UIRQ_STICKY_MASK});
      wr(`UIRQ_ENABLE_OFS, 32'h0);
      ev_p(6'b001100);
      ev_p(6'b000010);
      rd(`UIRQ_STATUS_OFS, 33'h0);
      ev_p(6'b100000);
      ev_p(6'b010000);
      ev_p(6'b001000);
      ev_p(6'b000011);
      rd(`UIRQ_STATUS_OFS, 33'h0_200E_0000);
      chk_irq(1'b0);
      wr(`UIRQ_ENABLE_OFS, 32'h0008_0000);
      chk_irq(1'b1);
      wr(`UIRQ_STATUS_OFS, 32'h0008_0000);
      chk_irq(1'b0);
      rd(`UIRQ_STATUS_OFS, 33'h0_2006_0000);
      wr(`UIRQ_STATUS_OFS, 32'hFFFF_FFFF);
      rd(`UIRQ_STATUS_OFS, 33'h0);
      // A new completion at the very edge of its clear must survive the clear.
      ev_p(6'b010000);
      fork
         wr(`UIRQ_STATUS_OFS, 32'h0004_0000);
         begin
            @(posedge pclk);
            ev_p(6'b010000);
         end
      join
      rd(`UIRQ_STATUS_OFS, 33'h0_0004_0000);
      wr(`UIRQ_STATUS_OFS, 32'hFFFF_FFFF);
      $display("test master_write done");
      setc(10'h200);
      rd(`UIRQ_STATUS_OFS, 33'h0_0000_0200);
      rd(`UIRQ_POWER_OFS, 33'h1);
      setc(10'h000);
      rd(`UIRQ_STATUS_OFS, 33'h0_0000_0600);
      rd(`UIRQ_POWER_OFS, 33'h0);
      setc(10'h100);
      rd(`UIRQ_STATUS_OFS, 33'h0_0000_0700);
      rd(`UIRQ_POWER_OFS, 33'h2);
      wr(`UIRQ_STATUS_OFS, 32'h0000_0100);
      setc(10'h000);
      rd(`UIRQ_STATUS_OFS, 33'h0_0000_0700);
      wr(`UIRQ_ENABLE_OFS, 32'h0000_0400);
      chk_irq(1'b1);
      wr(`UIRQ_STATUS_OFS, 32'hFFFF_FFFF);
      chk_irq(1'b0);
      // The clock enable stalls a read; the master must wait for the answer.
      @(posedge pclk);
      clk_en <= 1'b0;
      fork
         rd(`UIRQ_ENABLE_OFS, 33'h0_0000_0400);
         begin
            repeat (3) @(posedge pclk);
            clk_en <= 1'b1;
         end
      join
      $display("test core_events done");
      d = $urandom;
      setc({2'b00, d[7:0]});
      wr(`UIRQ_STATUS_OFS, 32'h0000_00FF);
      rd(`UIRQ_STATUS_OFS, {25'h0, d[7:0]});
      setc(10'h0FF);
      rd(`UIRQ_STATUS_OFS, 33'h0_0000_00FF);
      chk_irq(1'b0);
      setc(10'h000);
      rd(`UIRQ_STATUS_OFS, 33'h0);
      $display("test mirrors done");
      wrap_up();
   end
endmodule : tb_top

/* File: verification/uirq_core_model.sv */
// Behavioural model of the controller core's flag outputs.
`timescale 1ns/1ps

module uirq_core_model
   import uirq_pkg::*;
(
   // Flag levels requested by the bench.
   input wire logic [9:0] req,
   // Flag outputs; the skew makes them change 7 ns after the bus clock edge that drives req.
   output uirq_core_flags_t core_flags
);
   assign #7 core_flags = uirq_core_flags_t'(req);
endmodule : uirq_core_model
